// File: hw/vdf_defs.vh
`ifndef VDF_DEFS_VH
`define VDF_DEFS_VH
// =====================================================
// register offsets (byte addresses)
`define VDF_REG_CTRL      8'h00
`define VDF_REG_STATUS    8'h04
`define VDF_REG_VID       8'h08
`define VDF_REG_IRQ_STAT  8'h0c
`define VDF_REG_IRQ_MASK  8'h10
`define VDF_REG_ADC_CTRL  8'h14
`define VDF_REG_ADC_BASE  8'h20
`define VDF_REG_ADC_LAST  8'h40
// =====================================================
// reset values
`define VDF_CTRL_RST      16'h0410
`define VDF_MASK_RST      11'h000
// =====================================================
// field positions
`define VDF_CTRL_ONT_LSB  0
`define VDF_CTRL_SLEW_LSB 8
`define VDF_IRQ_FAULT_LSB 0
`define VDF_IRQ_VID       8
`define VDF_IRQ_SS_DONE   9
`define VDF_IRQ_LOCKOUT   10
`define VDF_IRQ_W         11
// =====================================================
// voltage-id decode, last adc source
`define VDF_VID_ZERO      8'hf8
`define VDF_VID_BND_FIRST 8'ha8
`define VDF_LEVEL_TOP     8'hf8
`define VDF_ADC_LAST_SRC  4'h8
// =====================================================
// timing
`define VDF_CLK_NS        100
`define VDF_LINK_IDLE_NS  10000
`define VDF_LINK_IDLE_CYC (`VDF_LINK_IDLE_NS / `VDF_CLK_NS)
// =====================================================
// sequencer states
`define VDF_ST_LOCK       2'h0
`define VDF_ST_IDLE       2'h1
`define VDF_ST_SOFT       2'h2
`define VDF_ST_RUN        2'h3
`endif

// File: hw/vdf_ontime.v
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// one phase on-time pulse, balanced against the average
module vdf_ontime #(
   parameter W = 8
) (
   // clock
   input  wire         core_clk,
   input  wire         rst_n,
   input  wire         clk_en,
   // control
   input  wire         trigger,
   input  wire [W-1:0] on_time,
   input  wire [W-1:0] cur,
   input  wire [W-1:0] avg,
   // pulse
   output reg          pulse
);
   reg  [W+1:0] cnt;
   wire [W+1:0] sum = {2'b00, on_time} + {2'b00, avg};
   wire [W+1:0] cw  = {2'b00, cur};
   // hot phase gets shorter, cold phase longer
   wire [W+1:0] len = (sum > cw) ? (sum - cw) : {{(W+1){1'b0}}, 1'b1};

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt   <= {(W+2){1'b0}};
         pulse <= 1'b0;
      end else if (clk_en) begin
         if (trigger && !pulse) begin
            cnt   <= len - 1'b1;
            pulse <= 1'b1;
         end else if (pulse) begin
            if (cnt == {(W+2){1'b0}})
               pulse <= 1'b0;
            else
               cnt <= cnt - 1'b1;
         end
      end
   end
endmodule // vdf_ontime
`default_nettype wire

// File: hw/vdf_top.v
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "vdf_defs.vh"
module vdf_top #(
   parameter [7:0] BOOT_VID    = 8'h40,
   parameter       CORE_PHASES = 4,
   parameter       NB_PHASES   = 2
) (
   // clock, reset, enable
   input  wire                                core_clk,
   input  wire                                rst_b,
   input  wire                                clk_en,
   // apb slave
   input  wire [7:0]                          paddr,
   input  wire                                psel,
   input  wire                                penable,
   input  wire                                pwrite,
   input  wire [31:0]                         pwdata,
   output reg  [31:0]                         prdata,
   output reg                                 pready,
   output reg                                 pslverr,
   // serial voltage-id link
   input  wire                                serial_vid_clock,
   input  wire                                serial_vid_data,
   output reg                                 telemetry_output,
   // platform pins
   input  wire                                system_power_ok,
   input  wire                                enable,
   input  wire                                driver_supply_detect,
   input  wire                                controller_supply_ok,
   input  wire [7:0]                          rail_fault_in,
   // references and sequencing
   output reg  [7:0]                          core_reference,
   output reg  [7:0]                          nb_reference,
   output reg                                 core_tolerance_band,
   output reg                                 nb_tolerance_band,
   output reg                                 core_output_off,
   output reg                                 nb_output_off,
   output reg                                 undervoltage_lockout,
   output reg                                 power_on_reset,
   output reg                                 soft_start_done,
   // open-drain pins, enable low drives
   output reg                                 core_power_good_out,
   output reg                                 core_power_good_oe_n,
   output reg                                 nb_power_good_out,
   output reg                                 nb_power_good_oe_n,
   output reg                                 overcurrent_alert_n_out,
   output reg                                 overcurrent_alert_n_oe_n,
   // adc
   output reg  [3:0]                          adc_mux_select,
   output reg                                 adc_start,
   input  wire                                adc_done,
   input  wire [9:0]                          adc_result,
   // phases
   input  wire [CORE_PHASES+NB_PHASES-1:0]    phase_trigger,
   input  wire [8*(CORE_PHASES+NB_PHASES)-1:0] phase_current,
   output wire [CORE_PHASES+NB_PHASES-1:0]    phase_pulse,
   // interrupt
   output reg                                 irq
);
   localparam NPH = CORE_PHASES + NB_PHASES;
   localparam integer IDLE_I  = `VDF_LINK_IDLE_CYC;
   localparam [15:0] IDLE_CYC = IDLE_I[15:0];

   // =====================================================
   // reset release and pin synchronisers
   reg         rst_m, rst_n;
   reg  [13:0] pin_s1, pin_s2;
   wire [13:0] pin_raw = {rail_fault_in, controller_supply_ok, driver_supply_detect,
                          enable, system_power_ok, serial_vid_data, serial_vid_clock};

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 14'h0000;
         pin_s2 <= 14'h0000;
      end else if (clk_en) begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   wire       lck_s   = pin_s2[0];
   wire       ldt_s   = pin_s2[1];
   wire       pok_s   = pin_s2[2];
   wire       en_s    = pin_s2[3];
   wire [7:0] fault_s = pin_s2[13:6];
   wire       lockout = ~(pin_s2[4] & pin_s2[5]);

   // =====================================================
   // registers
   reg  [15:0]            ctrl;
   reg  [`VDF_IRQ_W-1:0]  irq_stat, irq_mask;
   reg                    adc_scan;
   reg  [9:0]             adc_res [0:8];
   reg  [7:0]             core_vid, nb_vid;
   reg  [1:0]             state;
   wire [7:0]             on_time  = ctrl[`VDF_CTRL_ONT_LSB +: 8];
   wire [7:0]             slew_div = ctrl[`VDF_CTRL_SLEW_LSB +: 8];

   // =====================================================
   // voltage-id decode
   function [7:0] vdf_level;
      input [7:0] code;
      begin
         if (code > `VDF_VID_ZERO)
            vdf_level = 8'h00;
         else
            vdf_level = `VDF_LEVEL_TOP - code;
      end
   endfunction

   wire [7:0] core_tgt = vdf_level(core_vid);
   wire [7:0] nb_tgt   = vdf_level(nb_vid);

   // =====================================================
   // serial link receiver and telemetry
   reg        lck_p;
   reg  [3:0] bit_cnt;
   reg  [7:0] rx_sh, tx_sh;
   reg  [15:0] idle_cnt;
   reg        vid_evt;
   wire       lck_rise = lck_s & ~lck_p;
   wire       lck_fall = ~lck_s & lck_p;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lck_p            <= 1'b0;
         bit_cnt          <= 4'h0;
         rx_sh            <= 8'h00;
         tx_sh            <= 8'h00;
         idle_cnt         <= 16'h0000;
         vid_evt          <= 1'b0;
         telemetry_output <= 1'b0;
         core_vid         <= BOOT_VID;
         nb_vid           <= BOOT_VID;
      end else if (clk_en) begin
         lck_p   <= lck_s;
         vid_evt <= 1'b0;
         if (!pok_s) begin
            bit_cnt  <= 4'h0;
            idle_cnt <= 16'h0000;
            core_vid <= BOOT_VID;
            nb_vid   <= BOOT_VID;
            telemetry_output <= 1'b0;
         end else begin
            if (lck_rise || bit_cnt == 4'h0)
               idle_cnt <= 16'h0000;
            else if (idle_cnt == IDLE_CYC)
               bit_cnt <= 4'h0;
            else
               idle_cnt <= idle_cnt + 16'h0001;
            if (lck_rise) begin
               rx_sh <= {rx_sh[6:0], ldt_s};
               if (bit_cnt == 4'h0)
                  tx_sh <= core_reference;
               if (bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  vid_evt <= 1'b1;
                  if (rx_sh[7])
                     nb_vid <= {rx_sh[6:0], ldt_s};
                  else
                     core_vid <= {rx_sh[6:0], ldt_s};
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            if (lck_fall) begin
               telemetry_output <= tx_sh[7];
               tx_sh <= {tx_sh[6:0], 1'b0};
            end
         end
      end
   end

   // =====================================================
   // sequencer and reference slew
   reg  [7:0] slew_cnt;
   reg        ss_evt, lock_p;
   wire       tick    = (slew_cnt == 8'h00);
   wire       at_tgt  = (core_reference == core_tgt) && (nb_reference == nb_tgt);
   wire       ramping = (state == `VDF_ST_SOFT) || (state == `VDF_ST_RUN);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state          <= `VDF_ST_LOCK;
         slew_cnt       <= 8'h00;
         core_reference <= 8'h00;
         nb_reference   <= 8'h00;
         ss_evt         <= 1'b0;
         lock_p         <= 1'b1;
      end else if (clk_en) begin
         ss_evt   <= 1'b0;
         lock_p   <= lockout;
         slew_cnt <= tick ? slew_div : slew_cnt - 8'h01;
         case (state)
            `VDF_ST_LOCK: if (!lockout) state <= `VDF_ST_IDLE;
            `VDF_ST_IDLE: if (en_s) state <= `VDF_ST_SOFT;
            `VDF_ST_SOFT: if (at_tgt) begin
               state  <= `VDF_ST_RUN;
               ss_evt <= 1'b1;
            end
            `VDF_ST_RUN: state <= `VDF_ST_RUN;
            default: state <= `VDF_ST_LOCK;
         endcase
         if (lockout)
            state <= `VDF_ST_LOCK;
         else if (!en_s && ramping)
            state <= `VDF_ST_IDLE;
         if (!ramping) begin
            core_reference <= 8'h00;
            nb_reference   <= 8'h00;
         end else if (tick) begin
            if (core_reference < core_tgt)
               core_reference <= core_reference + 8'h01;
            else if (core_reference > core_tgt)
               core_reference <= core_reference - 8'h01;
            if (nb_reference < nb_tgt)
               nb_reference <= nb_reference + 8'h01;
            else if (nb_reference > nb_tgt)
               nb_reference <= nb_reference - 8'h01;
         end
      end
   end

   // =====================================================
   // status outputs and pin gating
   wire core_bad = |{fault_s[6], fault_s[4], fault_s[2], fault_s[0]};
   wire nb_bad   = |{fault_s[7], fault_s[5], fault_s[3], fault_s[1]};
   // drops in the same cycle as lockout, two synchroniser cycles after a supply pin fails
   wire run      = (state == `VDF_ST_RUN) && !lockout;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_tolerance_band      <= 1'b0;
         nb_tolerance_band        <= 1'b0;
         core_output_off          <= 1'b0;
         nb_output_off            <= 1'b0;
         undervoltage_lockout     <= 1'b1;
         power_on_reset           <= 1'b1;
         soft_start_done          <= 1'b0;
         core_power_good_out      <= 1'b0;
         core_power_good_oe_n     <= 1'b0;
         nb_power_good_out        <= 1'b0;
         nb_power_good_oe_n       <= 1'b0;
         overcurrent_alert_n_out  <= 1'b0;
         overcurrent_alert_n_oe_n <= 1'b1;
      end else if (clk_en) begin
         core_tolerance_band  <= (core_vid >= `VDF_VID_BND_FIRST);
         nb_tolerance_band    <= (nb_vid >= `VDF_VID_BND_FIRST);
         core_output_off      <= (core_vid > `VDF_VID_ZERO);
         nb_output_off        <= (nb_vid > `VDF_VID_ZERO);
         undervoltage_lockout <= lockout;
         power_on_reset       <= lockout;
         soft_start_done      <= run;
         core_power_good_oe_n <= run & ~core_bad;
         nb_power_good_oe_n   <= run & ~nb_bad;
         overcurrent_alert_n_oe_n <= ~(run & (fault_s[0] | fault_s[1]));
      end
   end

   // =====================================================
   // adc scan of nine sources
   reg adc_busy;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         adc_mux_select <= 4'h0;
         adc_start      <= 1'b0;
         adc_busy       <= 1'b0;
      end else if (clk_en) begin
         adc_start <= 1'b0;
         if (!adc_busy && adc_scan) begin
            adc_start <= 1'b1;
            adc_busy  <= 1'b1;
         end else if (adc_busy && adc_done) begin
            adc_busy <= 1'b0;
            if (adc_mux_select == `VDF_ADC_LAST_SRC)
               adc_mux_select <= 4'h0;
            else
               adc_mux_select <= adc_mux_select + 4'h1;
         end
      end
   end

   always @(posedge core_clk) begin
      if (clk_en && adc_busy && adc_done)
         adc_res[adc_mux_select] <= adc_result;
   end

   // =====================================================
   // on-time generators
   reg [9:0] core_sum, nb_sum;
   integer   k;

   always @* begin
      core_sum = 10'h000;
      nb_sum   = 10'h000;
      for (k = 0; k < NPH; k = k + 1) begin
         if (k < CORE_PHASES)
            core_sum = core_sum + {2'b00, phase_current[8*k +: 8]};
         else
            nb_sum = nb_sum + {2'b00, phase_current[8*k +: 8]};
      end
   end

   wire [31:0] core_div = core_sum / CORE_PHASES;
   wire [31:0] nb_div   = nb_sum / NB_PHASES;
   wire [9:0]  core_avg = core_div[9:0];
   wire [9:0]  nb_avg   = nb_div[9:0];

   genvar g;
   generate
      for (g = 0; g < NPH; g = g + 1) begin : g_ph
         vdf_ontime #(.W(8)) u_ont (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .clk_en   (clk_en),
            .trigger  (phase_trigger[g]),
            .on_time  (on_time),
            .cur      (phase_current[8*g +: 8]),
            .avg      ((g < CORE_PHASES) ? core_avg[7:0] : nb_avg[7:0]),
            .pulse    (phase_pulse[g])
         );
      end
   endgenerate

   // =====================================================
   // apb slave, one wait-free access phase
   reg  [31:0] next_prdata;
   reg         next_err;
   wire [7:0]  adc_off = paddr - `VDF_REG_ADC_BASE;
   wire        adc_hit = (paddr >= `VDF_REG_ADC_BASE) && (paddr <= `VDF_REG_ADC_LAST)
                         && (paddr[1:0] == 2'b00);
   wire        wr_go   = psel & penable & pready & pwrite & ~pslverr;
   wire [`VDF_IRQ_W-1:0] irq_set = {lockout & ~lock_p, ss_evt, vid_evt, fault_s};

   always @* begin
      next_prdata = 32'h0000_0000;
      next_err    = 1'b0;
      case (paddr)
         `VDF_REG_CTRL:     next_prdata = {16'h0000, ctrl};
         `VDF_REG_STATUS:   next_prdata = {24'h0000_00, 2'b00, core_output_off,
                                           nb_output_off, adc_busy, lockout, state};
         `VDF_REG_VID:      next_prdata = {nb_reference, core_reference, nb_vid, core_vid};
         `VDF_REG_IRQ_STAT: next_prdata = {21'h00_0000, irq_stat};
         `VDF_REG_IRQ_MASK: next_prdata = {21'h00_0000, irq_mask};
         `VDF_REG_ADC_CTRL: next_prdata = {31'h0000_0000, adc_scan};
         default: begin
            if (adc_hit)
               next_prdata = {22'h00_0000, adc_res[adc_off[5:2]]};
            else
               next_err = 1'b1;
         end
      endcase
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata   <= 32'h0000_0000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         ctrl     <= `VDF_CTRL_RST;
         irq_mask <= `VDF_MASK_RST;
         irq_stat <= {`VDF_IRQ_W{1'b0}};
         adc_scan <= 1'b0;
         irq      <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & next_err;
         if (psel && !penable)
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         if (wr_go && paddr == `VDF_REG_CTRL)
            ctrl <= pwdata[15:0];
         if (wr_go && paddr == `VDF_REG_IRQ_MASK)
            irq_mask <= pwdata[`VDF_IRQ_W-1:0];
         if (wr_go && paddr == `VDF_REG_ADC_CTRL)
            adc_scan <= pwdata[0];
         if (wr_go && paddr == `VDF_REG_IRQ_STAT)
            irq_stat <= (irq_stat & ~pwdata[`VDF_IRQ_W-1:0]) | irq_set;
         else
            irq_stat <= irq_stat | irq_set;
         irq <= |(irq_stat & irq_mask);
      end
   end
endmodule // vdf_top
`default_nettype wire

// File: sim/vdf_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ====================================================
// port checker for the sequencing and reference pins
module vdf_monitor (
   // clock, reset
   input wire logic       core_clk,
   input wire logic       rst_b,
   // watched pins
   input wire logic [7:0] rail_fault_in,
   input wire logic       driver_supply_detect,
   input wire logic       controller_supply_ok,
   input wire logic [7:0] core_reference,
   input wire logic       core_tolerance_band,
   input wire logic       core_output_off,
   input wire logic       undervoltage_lockout,
   input wire logic       power_on_reset,
   input wire logic       soft_start_done,
   input wire logic       core_power_good_oe_n,
   input wire logic       nb_power_good_oe_n,
   input wire logic       overcurrent_alert_n_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_lock_por: assert property ((!driver_supply_detect || !controller_supply_ok) [*4]
      |-> undervoltage_lockout && power_on_reset)
      else $error("supply low without lockout and power-on reset");
   a_run_supply: assert property (soft_start_done |-> !undervoltage_lockout)
      else $error("run state during lockout");
   a_pins_held: assert property (!soft_start_done [*3]
      |-> !core_power_good_oe_n && !nb_power_good_oe_n && overcurrent_alert_n_oe_n)
      else $error("status pins released before soft-start end");
   a_good_in_run: assert property (core_power_good_oe_n || nb_power_good_oe_n
      |-> soft_start_done || $past(soft_start_done))
      else $error("power good outside run");
   a_ocp_alert: assert property ((soft_start_done && (|rail_fault_in[1:0])) [*4]
      |-> !overcurrent_alert_n_oe_n)
      else $error("overcurrent alert not pulled low");
   a_core_fault: assert property ((soft_start_done && (|(rail_fault_in & 8'h55))) [*4]
      |-> !core_power_good_oe_n)
      else $error("core power good kept during core fault");
   a_off_band: assert property (core_output_off |-> core_tolerance_band)
      else $error("off code without tolerance band");
   a_ref_slew: assert property (soft_start_done && $past(soft_start_done)
      && !core_output_off && $changed(core_reference)
      |-> 8'(core_reference - $past(core_reference)) inside {8'h01, 8'hff})
      else $error("core reference stepped by more than one");
   c_run: cover property ($rose(soft_start_done));
   c_alert: cover property (soft_start_done && !overcurrent_alert_n_oe_n);
   c_off: cover property (core_output_off);
endmodule // vdf_monitor
bind vdf_top vdf_monitor u_mon (.core_clk, .rst_b, .rail_fault_in, .core_reference,
   .driver_supply_detect, .controller_supply_ok,
   .core_tolerance_band, .core_output_off, .undervoltage_lockout, .power_on_reset,
   .soft_start_done, .core_power_good_oe_n, .nb_power_good_oe_n, .overcurrent_alert_n_oe_n);
`default_nettype wire

// File: sim/vdf_host.sv
`timescale 1ns/1ns
`default_nettype none
// ====================================================
// processor side of the voltage-id link
module vdf_host (
   // link
   output var logic serial_vid_clock,
   output var logic serial_vid_data,
   input  wire logic telemetry_output
);
   // last telemetry byte seen, msb first
   logic [7:0] tel;
   initial begin
      serial_vid_clock = 1'h0;
      serial_vid_data  = 1'h0;
   end
   // one frame: rail bit, then code msb first
   task automatic send(input logic rail, input logic [7:0] code);
      logic [8:0] f;
      f = {rail, code};
      #37;
      for (int i = 8; i >= 0; i--) begin
         serial_vid_data = f[i];
         #400 tel = {tel[6:0], telemetry_output};
         serial_vid_clock = 1'h1;
         #400 serial_vid_clock = 1'h0;
      end
      // released data line shows no stale bit
      serial_vid_data = ~serial_vid_data;
   endtask
endmodule // vdf_host
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "vdf_defs.vh"
module tb_top;
   logic        core_clk = 0, rst_b = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = '0, rail_fault_in = '0, core_reference, nb_reference;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, err, telemetry_output, adc_done = 0, adc_start, irq;
   logic        system_power_ok = 1, enable = 0, driver_supply_detect = 0;
   logic        controller_supply_ok = 1, core_tolerance_band, nb_tolerance_band;
   logic        core_output_off, nb_output_off, undervoltage_lockout, power_on_reset;
   logic        soft_start_done, core_power_good_out, core_power_good_oe_n;
   logic        nb_power_good_out, nb_power_good_oe_n, overcurrent_alert_n_out;
   logic        overcurrent_alert_n_oe_n, serial_vid_clock, serial_vid_data;
   logic [3:0]  adc_mux_select;
   logic [9:0]  adc_result = '0;
   logic [5:0]  phase_trigger = '0, phase_pulse;
   logic [47:0] phase_current = {6{8'h20}};
   logic [7:0]  codes [7] = '{8'h00, 8'hf9, 8'h53, 8'hff, 8'ha8, 8'ha7, 8'hf8};
   int          n_errors = 0, compares = 0, pw;
   logic [7:0]  ex = 8'hb8;
   vdf_host host (.serial_vid_clock, .serial_vid_data, .telemetry_output);
   vdf_top #(.BOOT_VID(8'h40)) uut (.core_clk, .rst_b, .clk_en, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .serial_vid_clock, .serial_vid_data,
      .telemetry_output, .system_power_ok, .enable, .driver_supply_detect,
      .controller_supply_ok, .rail_fault_in, .core_reference, .nb_reference,
      .core_tolerance_band, .nb_tolerance_band, .core_output_off, .nb_output_off,
      .undervoltage_lockout, .power_on_reset, .soft_start_done, .core_power_good_out,
      .core_power_good_oe_n, .nb_power_good_out, .nb_power_good_oe_n,
      .overcurrent_alert_n_out, .overcurrent_alert_n_oe_n, .adc_mux_select, .adc_start,
      .adc_done, .adc_result, .phase_trigger, .phase_current, .phase_pulse, .irq);
   always #50 core_clk = ~core_clk;
   // converter stand-in: result tagged with its source
   always @(posedge core_clk) begin
      adc_done   <= adc_start;
      adc_result <= {6'h2a, adc_mux_select};
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic give_up;
      n_errors++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) give_up;
      q = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic wait_ref(input logic [7:0] e);
      int n;
      n = 0;
      while (core_reference !== e) begin
         @(posedge core_clk);
         if (++n > 900) give_up;
      end
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge core_clk);
      apb(1'h0, `VDF_REG_STATUS, '0);
      chk(q[2], 1'h1);
      chk(power_on_reset, 1'h1);
      apb(1'h1, `VDF_REG_CTRL, 32'h0000_0010);
      enable <= 1'h1;
      repeat (20) @(posedge core_clk);
      chk(soft_start_done, 1'h0);
      driver_supply_detect <= 1'h1;
      wait_ref(8'hb8);
      chk(undervoltage_lockout, 1'h0);
      repeat (4) @(posedge core_clk);
      chk(soft_start_done, 1'h1);
      chk(core_power_good_oe_n, 1'h1);
      chk(nb_reference, 8'hb8);
      for (int j = 0; j < 2; j++) begin
         phase_current[7:0] <= j ? 8'h28 : 8'h20;
         phase_trigger <= 6'h01;
         @(posedge core_clk);
         phase_trigger <= 6'h00;
         pw = 0;
         repeat (40) @(posedge core_clk) pw += (phase_pulse[0] === 1'h1);
         chk(pw, j ? 10 : 16);
      end
      $display("test startup done");
      foreach (codes[i]) begin
         host.send(1'h0, codes[i]);
         chk(host.tel, ex);
         ex = codes[i] > 8'hf8 ? 8'h00 : 8'hf8 - codes[i];
         @(posedge core_clk);
         wait_ref(ex);
         chk(core_tolerance_band, codes[i] >= 8'ha8);
         chk(core_output_off, codes[i] > 8'hf8);
         chk(nb_reference, 8'hb8);
      end
      host.send(1'h0, 8'h40);
      host.send(1'h1, 8'h10);
      wait_ref(8'hb8);
      apb(1'h0, `VDF_REG_VID, '0);
      chk(q, 32'he8b8_1040);
      $display("test codes done");
      apb(1'h1, `VDF_REG_IRQ_STAT, 32'h0000_07ff);
      apb(1'h1, `VDF_REG_IRQ_MASK, 32'h0000_0001);
      rail_fault_in <= 8'h01;
      repeat (5) @(posedge core_clk);
      chk(overcurrent_alert_n_oe_n, 1'h0);
      chk(irq, 1'h1);
      rail_fault_in <= 8'h04;
      repeat (5) @(posedge core_clk);
      chk(overcurrent_alert_n_oe_n, 1'h1);
      chk(core_power_good_oe_n, 1'h0);
      chk(nb_power_good_oe_n, 1'h1);
      rail_fault_in <= 8'h00;
      repeat (3) @(posedge core_clk);
      apb(1'h1, `VDF_REG_IRQ_STAT, 32'h0000_0001);
      repeat (3) @(posedge core_clk);
      chk(irq, 1'h0);
      apb(1'h0, `VDF_REG_IRQ_STAT, '0);
      chk(q[2:0], 3'h4);
      $display("test faults done");
      apb(1'h1, `VDF_REG_ADC_CTRL, 32'h0000_0001);
      repeat (200) @(posedge core_clk);
      apb(1'h1, `VDF_REG_ADC_CTRL, 32'h0000_0000);
      for (int s = 0; s < 9; s++) begin
         apb(1'h0, `VDF_REG_ADC_BASE + 8'(4 * s), '0);
         chk(q[9:0], {6'h2a, 4'(s)});
      end
      apb(1'h0, 8'h44, '0);
      chk(err, 1'h1);
      $display("test adc done");
      system_power_ok <= 1'h0;
      repeat (5) @(posedge core_clk);
      host.send(1'h0, 8'h20);
      chk(host.tel, 8'h00);
      @(posedge core_clk);
      apb(1'h0, `VDF_REG_VID, '0);
      chk(q[15:0], 16'h4040);
      controller_supply_ok <= 1'h0;
      repeat (5) @(posedge core_clk);
      chk(undervoltage_lockout, 1'h1);
      chk(core_power_good_oe_n, 1'h0);
      $display("test power loss done");
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire
